// ---- logic/pbsc_defines.vh ----
// Constants for the pipelined burst static memory core
`ifndef PBSC_DEFINES_VH
`define PBSC_DEFINES_VH
// Widths
`define PBSC_ADDR_W 18
`define PBSC_LANES 4
// Burst field: two lowest address bits
`define PBSC_BURST_W 2
// Sleep entry and exit in clock cycles
`define PBSC_SLEEP_CYC 2'h2
// Sleep recovery time in clock periods, and derived count
`define PBSC_SLEEP_REC_PERIODS 2
`define PBSC_SLEEP_REC_CYC (`PBSC_SLEEP_REC_PERIODS)
// Power-up state of the output driver
`define PBSC_RST_DRIVE 1'h0
`endif

// ---- logic/pbsc_core.v ----
// Synchronous core of a pipelined burst static memory without turnaround cycles
`timescale 1ns/100ps
`include "pbsc_defines.vh"

// Notes on behaviour
// - Clock-qualify high freezes every pipeline stage, array write and output for that edge; sleep request and sleep control ignore it.
// - Read loads when qualified, all selects active, write strobe high, load.
// - Read data leaves the output register after the next edge if drive enabled.
// - After first read cycle, drivers follow output-drive-enable and internal control.
// - A new command is accepted every cycle, no wait states.
// - Deselect is pipelined; outputs tristate after the following edge.
// - Burst counter steps two low address bits, wraps within four words.
// - Burst-order input low gives linear, high gives interleaved order.
// - Advance high steps the counter and ignores selects and write strobe.
// - Read or write direction is captured at load and kept through the burst.
// - Write loads when qualified, all selects active, strobe low, load.
// - Edge after a write tristates data and parity whatever the drive enable.
// - Write data is latched at the second edge after the command.
// - Only byte lanes with active select and their parity are updated.
// - After deselect the controller loads a new address before continuing.
// - Sleep entry and exit each take two cycles, contents kept.
// - Interleaved beats are start bits XOR beat index.
// - Linear beats increment by one modulo four.
// - After power-up the device is deselected with lines tristated.
// - Write with no lane selected changes nothing and leaves lines tristated.
module pbsc_core #(
    parameter ADDR_W = `PBSC_ADDR_W,
    parameter LANES = `PBSC_LANES
) (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire clock_qualify_n_i,
    input wire chip_select_1_n_i,
    input wire chip_select_2_i,
    input wire chip_select_3_n_i,
    input wire advance_or_load_i,
    input wire write_strobe_n_i,
    input wire [LANES-1:0] byte_lane_write_n_i,
    input wire output_drive_en_n_i,
    input wire burst_order_i,
    input wire sleep_request_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire [8*LANES-1:0] data_i,
    input wire [LANES-1:0] parity_lines_i,
    output reg [8*LANES-1:0] data_o,
    output reg [LANES-1:0] parity_lines_o,
    output reg [LANES-1:0] data_oe_o,
    output reg sleep_active_o
);

    localparam DEPTH = 1 << ADDR_W;
    localparam W = 9 * LANES;

    // Sleep states, one-hot
    localparam S_RUN = 4'h1;
    localparam S_ENTER = 4'h2;
    localparam S_SLEEP = 4'h4;
    localparam S_EXIT = 4'h8;

    // =========================================================
    // Helpers
    // =========================================================
    // Next burst address bits for either order
    function [1:0] burst_addr;
        input [1:0] start;
        input [1:0] beat;
        input interleaved;
        begin
            if (interleaved) begin
                burst_addr = start ^ beat;
            end else begin
                burst_addr = start + beat;
            end
        end
    endfunction

    // Pack each lane of data with its parity bit
    function [W-1:0] pack_word;
        input [8*LANES-1:0] d;
        input [LANES-1:0] p;
        integer k;
        begin
            pack_word = {W{1'b0}};
            for (k = 0; k < LANES; k = k + 1) begin
                pack_word[9*k +: 9] = {p[k], d[8*k +: 8]};
            end
        end
    endfunction

    // =========================================================
    // Storage and pipeline registers
    // =========================================================
    // Array of words, each lane nine bits with parity on top
    reg [W-1:0] mem [0:DEPTH-1];

    reg [ADDR_W-1:0] base_ff;
    reg [1:0] beat_ff;
    reg is_write_ff;
    reg active_ff;
    reg order_ff;
    // Stage 1: command taken on last edge
    reg s1_rd_ff, s1_wr_ff;
    reg [ADDR_W-1:0] s1_addr_ff;
    reg [LANES-1:0] s1_be_ff;
    // Stage 2: write waiting for its data
    reg s2_wr_ff;
    reg [ADDR_W-1:0] s2_addr_ff;
    reg [LANES-1:0] s2_be_ff;
    reg [3:0] sleep_st_ff;
    reg [1:0] sleep_cnt_ff;

    wire all_sel = ~chip_select_1_n_i & chip_select_2_i & ~chip_select_3_n_i;
    wire sleeping = (sleep_st_ff != S_RUN);
    wire run = ~clock_qualify_n_i & ~sleeping;

    // Command decode for this edge
    reg nxt_rd, nxt_wr;
    reg [ADDR_W-1:0] nxt_addr;
    reg [1:0] nxt_beat;
    always @* begin
        nxt_rd = 1'b0;
        nxt_wr = 1'b0;
        nxt_beat = beat_ff;
        nxt_addr = base_ff;
        if (!advance_or_load_i) begin
            nxt_beat = 2'h0;
            nxt_addr = addr_i;
            nxt_rd = all_sel & write_strobe_n_i;
            nxt_wr = all_sel & ~write_strobe_n_i;
        end else if (active_ff) begin
            nxt_beat = beat_ff + 2'h1;
            nxt_addr = {base_ff[ADDR_W-1:2],
                        burst_addr(base_ff[1:0], beat_ff + 2'h1, order_ff)};
            nxt_rd = ~is_write_ff;
            nxt_wr = is_write_ff;
        end
    end

    // =========================================================
    // Command pipeline
    // =========================================================
    // one command per edge
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            base_ff <= {ADDR_W{1'b0}};
            beat_ff <= 2'h0;
            is_write_ff <= 1'b0;
            active_ff <= 1'b0;
            order_ff <= 1'b1;
            s1_rd_ff <= 1'b0;
            s1_wr_ff <= 1'b0;
            s1_addr_ff <= {ADDR_W{1'b0}};
            s1_be_ff <= {LANES{1'b1}};
            s2_wr_ff <= 1'b0;
            s2_addr_ff <= {ADDR_W{1'b0}};
            s2_be_ff <= {LANES{1'b1}};
        end else if (sleeping) begin
            active_ff <= 1'b0;
            s1_rd_ff <= 1'b0;
            s1_wr_ff <= 1'b0;
            s2_wr_ff <= 1'b0;
        end else if (run) begin
            beat_ff <= nxt_beat;
            if (!advance_or_load_i) begin
                base_ff <= addr_i;
                is_write_ff <= ~write_strobe_n_i;
                active_ff <= all_sel;
                order_ff <= burst_order_i;
            end
            s1_rd_ff <= nxt_rd;
            s1_wr_ff <= nxt_wr;
            s1_addr_ff <= nxt_addr;
            s1_be_ff <= byte_lane_write_n_i;
            s2_wr_ff <= s1_wr_ff;
            s2_addr_ff <= s1_addr_ff;
            s2_be_ff <= s1_be_ff;
        end
    end

    // =========================================================
    // Array write and read
    // =========================================================
    // Incoming write word, lanes packed with their parity
    wire [W-1:0] wr_word = pack_word(data_i, parity_lines_i);

    integer i;
    always @(posedge sys_clk_i) begin
        if (run && s2_wr_ff) begin
            for (i = 0; i < LANES; i = i + 1) begin
                if (!s2_be_ff[i]) begin
                    mem[s2_addr_ff][9*i +: 9] <= wr_word[9*i +: 9];
                end
            end
        end
    end

    // Read path with a bypass: a read right after a write to the same word
    // fetches on the edge that write lands, so the array alone would be stale
    reg [W-1:0] rd_word_ff;
    integer m;
    always @(posedge sys_clk_i) begin
        if (run && s1_rd_ff) begin
            rd_word_ff <= mem[s1_addr_ff];
            for (m = 0; m < LANES; m = m + 1) begin
                if (s2_wr_ff && (s2_addr_ff == s1_addr_ff) && !s2_be_ff[m]) begin
                    rd_word_ff[9*m +: 9] <= wr_word[9*m +: 9];
                end
            end
        end
    end

    // =========================================================
    // Output register and drivers
    // =========================================================
    integer j;

    // Array word split back onto data and parity pins
    always @* begin
        data_o = {8*LANES{1'b0}};
        parity_lines_o = {LANES{1'b0}};
        for (j = 0; j < LANES; j = j + 1) begin
            data_o[8*j +: 8] = rd_word_ff[9*j +: 8];
            parity_lines_o[j] = rd_word_ff[9*j + 8];
        end
    end

    // Drive enable registered; drive input sampled, not asynchronous here
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_oe_o <= {LANES{`PBSC_RST_DRIVE}};
        end else if (sleeping || sleep_request_i) begin
            data_oe_o <= {LANES{1'b0}};
        end else if (run) begin
            data_oe_o <= {LANES{s1_rd_ff & ~output_drive_en_n_i}};
        end
    end

    // =========================================================
    // Sleep control
    // =========================================================
    // two-cycle entry and exit
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sleep_st_ff <= S_RUN;
            sleep_cnt_ff <= 2'h0;
            sleep_active_o <= 1'b0;
        end else begin
            case (sleep_st_ff)
                S_RUN: begin
                    if (sleep_request_i) begin
                        sleep_st_ff <= S_ENTER;
                        sleep_cnt_ff <= 2'h1;
                    end
                end
                S_ENTER: begin
                    if (!sleep_request_i) begin
                        sleep_st_ff <= S_EXIT;
                        sleep_cnt_ff <= 2'h1;
                    end else if (sleep_cnt_ff == `PBSC_SLEEP_CYC - 2'h1) begin
                        sleep_st_ff <= S_SLEEP;
                        sleep_active_o <= 1'b1;
                    end else begin
                        sleep_cnt_ff <= sleep_cnt_ff + 2'h1;
                    end
                end
                S_SLEEP: begin
                    if (!sleep_request_i) begin
                        sleep_st_ff <= S_EXIT;
                        sleep_cnt_ff <= 2'h1;
                    end
                end
                S_EXIT: begin
                    if (sleep_request_i) begin
                        sleep_st_ff <= S_ENTER;
                        sleep_cnt_ff <= 2'h1;
                    end else if (sleep_cnt_ff == `PBSC_SLEEP_CYC - 2'h1) begin
                        sleep_st_ff <= S_RUN;
                        sleep_active_o <= 1'b0;
                    end else begin
                        sleep_cnt_ff <= sleep_cnt_ff + 2'h1;
                    end
                end
                default: begin
                    sleep_st_ff <= S_RUN;
                end
            endcase
        end
    end

endmodule // pbsc_core

// ---- verif/pbsc_core_properties.sv ----
// Port checks for the burst memory core
`timescale 1ns/100ps
// ======================================
// Checker
module pbsc_core_properties #(
    parameter LANES = 4
) (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire clock_qualify_n_i,
    input wire chip_select_1_n_i,
    input wire chip_select_2_i,
    input wire chip_select_3_n_i,
    input wire advance_or_load_i,
    input wire write_strobe_n_i,
    input wire output_drive_en_n_i,
    input wire sleep_request_i,
    input wire [8*LANES-1:0] data_o,
    input wire [LANES-1:0] data_oe_o,
    input wire sleep_active_o
);
    // Qualified edge, full select and load decode
    wire go = !clock_qualify_n_i && !sleep_request_i && !sleep_active_o;
    wire sel = !chip_select_1_n_i && chip_select_2_i && !chip_select_3_n_i;
    wire ld = go && !advance_or_load_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_rd_load; ld && sel && write_strobe_n_i; endsequence
    sequence s_wr_load; ld && sel && !write_strobe_n_i; endsequence
    AST_STALL_HOLD: assert property (clock_qualify_n_i && !sleep_request_i && !sleep_active_o
        |=> $stable(data_oe_o) && (data_oe_o == '0 || $stable(data_o)))
        else $error("outputs moved on a stalled edge");
    AST_READ_DRIVE: assert property (s_rd_load ##1 (go && !output_drive_en_n_i)
        |=> data_oe_o == '1) else $error("read data not driven");
    AST_OE_GATED: assert property (go && output_drive_en_n_i |=> data_oe_o == '0)
        else $error("driving while drive enable is high");
    AST_DESELECT_TRI: assert property (ld && !sel ##1 go |=> data_oe_o == '0)
        else $error("driving after deselect");
    AST_WRITE_TRI: assert property (s_wr_load ##1 go |=> data_oe_o == '0)
        else $error("driving in write data slot");
    AST_BEAT_READ: assert property (s_rd_load ##1 (go && advance_or_load_i)
        ##1 (go && !output_drive_en_n_i) |=> data_oe_o == '1) else $error("read beat lost");
    AST_SLEEP_ENTER: assert property (sleep_request_i [*3] |=> sleep_active_o)
        else $error("sleep entry too slow");
    AST_SLEEP_EXIT: assert property (!sleep_request_i [*3] |=> !sleep_active_o)
        else $error("sleep exit too slow");
    AST_SLEEP_QUIET: assert property (sleep_active_o |-> data_oe_o == '0)
        else $error("driving while asleep");
endmodule // pbsc_core_properties

bind pbsc_core pbsc_core_properties #(.LANES(LANES)) u_props (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clock_qualify_n_i(clock_qualify_n_i),
    .chip_select_1_n_i(chip_select_1_n_i), .chip_select_2_i(chip_select_2_i),
    .chip_select_3_n_i(chip_select_3_n_i), .advance_or_load_i(advance_or_load_i),
    .write_strobe_n_i(write_strobe_n_i), .output_drive_en_n_i(output_drive_en_n_i),
    .sleep_request_i(sleep_request_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .sleep_active_o(sleep_active_o)
);

// ---- verif/pbsc_ctrl_model.sv ----
// Controller side write data source
`timescale 1ns/100ps
// ======================================
// Controller model
module pbsc_ctrl_model (
    input wire sys_clk_i,
    input wire clock_qualify_n_i,
    input wire wr_valid_i,
    input wire [35:0] wr_word_i,
    output reg [31:0] data_o = 32'h0,
    output reg [3:0] parity_lines_o = 4'h0
);
    reg [36:0] stage0_ff = 37'h0;
    reg [36:0] stage1_ff = 37'h0;
    always @(posedge sys_clk_i) begin
        if (!clock_qualify_n_i) begin
            stage0_ff <= {wr_valid_i, wr_word_i};
            stage1_ff <= stage0_ff;
        end
    end
    // released lines toggle, never hold stale data
    always @(negedge sys_clk_i) begin
        if (stage1_ff[36]) begin
            {parity_lines_o, data_o} <= stage1_ff[35:0];
        end else begin
            {parity_lines_o, data_o} <= ~{parity_lines_o, data_o};
        end
    end
endmodule // pbsc_ctrl_model

// ---- verif/pipelined_burst_sram_core_bench.sv ----
// Self-checking bench for the burst memory core
`timescale 1ns/100ps
// ======================================
// Bench top
module pipelined_burst_sram_core_bench;
    reg clk = 1'b0, rstn = 1'b0, qn = 1'b0, adv = 1'b0, wen = 1'b1, oen = 1'b0;
    reg cs1n = 1'b1, cs2 = 1'b0, cs3n = 1'b1, mode = 1'b0, slp = 1'b0, wv = 1'b0;
    reg bact = 1'b0, bwr = 1'b0, bord = 1'b0, exp_oe = 1'b0, nxt_mode = 1'b0;
    reg [3:0] bwn = 4'hF, base = 4'h0, idx;
    reg [1:0] bidx = 2'h0;
    reg [17:0] addr = 18'h0;
    reg [35:0] wword = 36'h0, exp_w = 36'h0;
    reg [35:0] mem [0:15];
    reg [36:0] pipe0 = 37'h0, ent;
    wire [31:0] din, dout;
    wire [3:0] pin, pout, oe;
    wire sact;
    integer fail_count = 0, samples_checked = 0, i, j, k;
    pbsc_core u_dut (.sys_clk_i(clk), .rstn_i(rstn), .clock_qualify_n_i(qn),
        .chip_select_1_n_i(cs1n), .chip_select_2_i(cs2), .chip_select_3_n_i(cs3n),
        .advance_or_load_i(adv), .write_strobe_n_i(wen), .byte_lane_write_n_i(bwn),
        .output_drive_en_n_i(oen), .burst_order_i(mode), .sleep_request_i(slp),
        .addr_i(addr), .data_i(din), .parity_lines_i(pin), .data_o(dout),
        .parity_lines_o(pout), .data_oe_o(oe), .sleep_active_o(sact));
    pbsc_ctrl_model u_ctrl (.sys_clk_i(clk), .clock_qualify_n_i(qn), .wr_valid_i(wv),
        .wr_word_i(wword), .data_o(din), .parity_lines_o(pin));
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Expected word index of a burst beat
    function [3:0] beat_index(input [3:0] b0, input [1:0] n, input ilv);
        beat_index = {b0[3:2], ilv ? b0[1:0] ^ n : b0[1:0] + n};
    endfunction
    task check(input [63:0] name, input [35:0] exp, input [35:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD %0s exp %h got %h", name, exp, got);
            end
        end
    endtask
    // One cycle: drive at falling edge, model in program order, check after edge
    task step(input a, input [2:0] c, input w, input [3:0] b, input [3:0] ad, input o, input q);
        begin
            @(negedge clk);
            mode = nxt_mode;
            {adv, cs1n, cs2, cs3n, wen, bwn, oen, qn} = {a, c, w, b, o, q};
            addr = {14'h0, ad};
            wv = 1'b0;
            ent = 37'h0;
            if (!q) begin
                if (!a) begin
                    {bact, bwr, bord, base, bidx} = {c == 3'h2, !w, mode, ad, 2'h0};
                end else begin
                    bidx = bidx + 2'h1;
                end
                idx = beat_index(base, bidx, bord);
                if (bact && bwr) begin
                    wword = {4'($urandom), $urandom};
                    wv = 1'b1;
                    for (k = 0; k < 4; k = k + 1) begin
                        if (!b[k]) begin
                            mem[idx][8*k +: 8] = wword[8*k +: 8];
                            mem[idx][32+k] = wword[32+k];
                        end
                    end
                end
                if (bact && !bwr) ent = {1'b1, mem[idx]};
            end
            @(posedge clk);
            #1;
            if (!q) begin
                {exp_oe, exp_w} = {pipe0[36] && !o, pipe0[35:0]};
                pipe0 = ent;
            end
            check("oe", {32'h0, {4{exp_oe}}}, {32'h0, oe});
            if (exp_oe) check("word", exp_w, {pout, dout});
        end
    endtask
    task final_report;
        begin
            if (fail_count == 0 && samples_checked > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        i = $urandom(32'h48D9DF42);
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        check("oe_rst", 36'h0, {32'h0, oe});
        for (i = 0; i < 4; i = i + 1) begin
            for (j = 0; j < 4; j = j + 1) begin
                step(j != 0, 3'h2, 1'b0, 4'h0, {i[1:0], 2'h3}, 1'b0, 1'b0);
            end
        end
        nxt_mode = 1'b1;
        for (i = 0; i < 16; i = i + 1) begin
            step(i[1:0] != 0, i[1:0] != 0 ? 3'($urandom) : 3'h2, i[1:0] != 0 ? 1'($urandom) :
                1'b1, 4'($urandom), {i[3:2], 2'h2}, 1'b0, 1'b0);
        end
        repeat (3) step(1'b0, 3'h0, 1'b1, 4'hF, 4'h0, 1'b0, 1'b0);
        @(negedge clk);
        slp = 1'b1;
        repeat (3) step(1'b0, 3'h0, 1'b1, 4'hF, 4'h0, 1'b0, 1'b0);
        check("sleep", 36'h1, {35'h0, sact});
        @(negedge clk);
        slp = 1'b0;
        repeat (3) step(1'b0, 3'h0, 1'b1, 4'hF, 4'h0, 1'b0, 1'b0);
        check("wake", 36'h0, {35'h0, sact});
        for (i = 0; i < 600; i = i + 1) begin
            nxt_mode = 1'($urandom);
            step(($urandom % 3) == 0, ($urandom % 4) == 0 ? 3'($urandom) : 3'h2, 1'($urandom),
                4'($urandom), 4'($urandom), ($urandom % 8) == 0, ($urandom % 8) == 0);
        end
        final_report;
    end
endmodule // pipelined_burst_sram_core_bench
